// file: logic/irq_unit_map.svh
/*
  Constants for the interrupt response unit: restart addresses, mode codes, timing counts.
  Assumes inclusion by bare name from the logic folder.
*/
`ifndef IRQ_UNIT_MAP_SVH
`define IRQ_UNIT_MAP_SVH
`define NMI_RESTART_ADDR 16'h0066
`define MODE1_RESTART_ADDR 16'h0038
`define MODE_0 2'h0
`define MODE_1 2'h1
`define MODE_2 2'h2
`define ACK_WAIT_STATES 2'h2
`define CALL_OPCODE 8'hcd
`define REFRESH_LOW_MASK 8'h7f
`define VECTOR_BASE_RESET 8'h00
`define REFRESH_RESET 8'h00
`endif

// file: logic/irq_unit_pkg.sv
/*
  Types for the interrupt response unit.
  Assumes no imports; users reference names with the package scope.
*/
package irq_unit_pkg;
  typedef enum logic [5:0] {
    st_idle = 6'h01,
    st_ack = 6'h02,
    st_wait = 6'h04,
    st_call_lo = 6'h08,
    st_call_hi = 6'h10,
    st_table = 6'h20
  } phase_type;
endpackage

// file: logic/cpu_interrupt_response_unit.sv
/*
  Interrupt acceptance, acknowledge cycle, response modes, enable flops and vector/refresh regs.
  Assumes the core pulses instruction boundary, fetch and instruction-decode strobes and
  returns memory read data for the service-address fetches.
*/
// What the document requires
// [RULE_01] Non-maskable request is always accepted and wins over the maskable one; the code holds it off while bus hold request is active.
// [RULE_02] Maskable request acts only when enabled and bus hold request is inactive.
// [RULE_03] Both requests are sampled on the last clock of each instruction.
// [RULE_04] Accepted non-maskable request jumps to restart address 0066H.
// [RULE_05] Maskable acknowledge is an opcode fetch with io strobe, not memory strobe.
// [RULE_06] Acknowledge cycle is stretched by two wait states.
// [RULE_07] Three selectable maskable modes; non-maskable has one fixed response.
// [RULE_08] In mode 0 the peripheral drives an instruction, usually a restart.
// [RULE_09] Mode 0 call: one acknowledge cycle, then two memory reads for address.
// [RULE_10] Mode 1 behaves like non-maskable but vectors to 0038H.
// [RULE_11] Mode 2 pointer is vector base high byte and acknowledged byte low.
// [RULE_12] Mode 2 peripheral vector must have bit 0 clear.
// [RULE_13] Peripherals chain priority through enable-in to enable-out.
// [RULE_14] A peripheral holds enable-out low until its service ends.
// [RULE_15] Peripherals may share the maskable request line wired-OR.
// [RULE_16] Pending requests are held and served later in nested order.
// [RULE_17] Reset and disable instruction clear both enable flops.
// [RULE_18] Enable instruction sets both enable flops.
// [RULE_19] Non-maskable accept copies primary into secondary, then clears primary.
// [RULE_20] Return-from-nonmaskable restores primary from secondary.
// [RULE_21] Reading vector base or refresh copies secondary into parity flag.
// [RULE_22] Refresh low seven bits increment per fetch; all eight drive the address.
`timescale 1ns/1ps
`include "irq_unit_map.svh"
module cpu_interrupt_response_unit
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic nmi_request_b,
  input wire logic int_request_b,
  input wire logic bus_hold_request_b,
  input wire logic instr_last_clock,
  input wire logic fetch_done,
  input wire logic disable_instruction,
  input wire logic enable_instruction,
  input wire logic return_from_nonmaskable,
  input wire logic [1:0] set_mode,
  input wire logic set_mode_strobe,
  input wire logic vector_base_write,
  input wire logic refresh_write,
  input wire logic [7:0] write_data,
  input wire logic read_special,
  input wire logic [7:0] data_in,
  output logic opcode_fetch_cycle_b,
  output logic io_request_strobe_b,
  output logic memory_request_strobe_b,
  output logic [15:0] address_out,
  output logic refresh_phase,
  output logic [7:0] interrupt_vector_base,
  output logic [7:0] memory_refresh_counter,
  output logic primary_enable_flop,
  output logic secondary_enable_flop,
  output logic [1:0] response_mode_flops,
  output logic parity_flag,
  output logic parity_flag_valid,
  output logic [15:0] service_address,
  output logic service_valid,
  output logic [7:0] injected_opcode,
  output logic injected_valid,
  output logic busy
);
  typedef struct packed {
    irq_unit_pkg::phase_type phase;
    logic [1:0] wait_count;
    logic is_call;
    logic [7:0] ack_byte;
    logic [7:0] addr_lo;
    logic opcode_fetch_cycle_b;
    logic io_request_strobe_b;
    logic memory_request_strobe_b;
    logic [15:0] address_out;
    logic refresh_phase;
    logic [7:0] interrupt_vector_base;
    logic [7:0] memory_refresh_counter;
    logic primary_enable_flop;
    logic secondary_enable_flop;
    logic [1:0] response_mode_flops;
    logic parity_flag;
    logic parity_flag_valid;
    logic [15:0] service_address;
    logic service_valid;
    logic [7:0] injected_opcode;
    logic injected_valid;
    logic busy;
  } state_type;

  state_type state;
  state_type next_state;
  logic rst_meta;
  logic rst_sync_b;

  function automatic logic [7:0] bump_refresh(input logic [7:0] value);
    bump_refresh = {value[7], 7'(value[6:0] + 7'h01)};
  endfunction

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  always_comb
  begin
    next_state = state;
    next_state.service_valid = 1'b0;
    next_state.injected_valid = 1'b0;
    next_state.parity_flag_valid = 1'b0;
    next_state.refresh_phase = 1'b0;
    next_state.opcode_fetch_cycle_b = 1'b1;
    next_state.io_request_strobe_b = 1'b1;
    next_state.memory_request_strobe_b = 1'b1;
    if (fetch_done)
    begin
      // Refresh slot follows every opcode fetch
      next_state.memory_refresh_counter = bump_refresh(state.memory_refresh_counter); // [RULE_22]
      next_state.refresh_phase = 1'b1;
      next_state.address_out = {state.interrupt_vector_base, state.memory_refresh_counter}; // [RULE_22]
    end
    if (vector_base_write)
      next_state.interrupt_vector_base = write_data;
    if (refresh_write)
      next_state.memory_refresh_counter = write_data;
    if (read_special)
    begin
      next_state.parity_flag = state.secondary_enable_flop; // [RULE_21]
      next_state.parity_flag_valid = 1'b1;
    end
    if (set_mode_strobe && set_mode != 2'h3)
      next_state.response_mode_flops = set_mode; // [RULE_07]
    if (disable_instruction)
    begin
      next_state.primary_enable_flop = 1'b0; // [RULE_17]
      next_state.secondary_enable_flop = 1'b0; // [RULE_17]
    end
    else if (enable_instruction)
    begin
      next_state.primary_enable_flop = 1'b1; // [RULE_18]
      next_state.secondary_enable_flop = 1'b1; // [RULE_18]
    end
    else if (return_from_nonmaskable)
      next_state.primary_enable_flop = state.secondary_enable_flop; // [RULE_20]
    case (state.phase)
      irq_unit_pkg::st_idle:
      begin
        // Request lines are levels, so an unserved request stays pending
        if (instr_last_clock && bus_hold_request_b) // [RULE_03] [RULE_16]
        begin
          if (!nmi_request_b) // [RULE_01]
          begin
            next_state.secondary_enable_flop = state.primary_enable_flop; // [RULE_19]
            next_state.primary_enable_flop = 1'b0; // [RULE_19]
            next_state.service_address = `NMI_RESTART_ADDR; // [RULE_04]
            next_state.service_valid = 1'b1;
          end
          else if (!int_request_b && state.primary_enable_flop) // [RULE_02] [RULE_15]
          begin
            next_state.primary_enable_flop = 1'b0;
            next_state.secondary_enable_flop = 1'b0;
            if (state.response_mode_flops == `MODE_1)
            begin
              next_state.service_address = `MODE1_RESTART_ADDR; // [RULE_10]
              next_state.service_valid = 1'b1;
            end
            else
            begin
              next_state.phase = irq_unit_pkg::st_ack;
              next_state.opcode_fetch_cycle_b = 1'b0;
            end
          end
        end
      end
      irq_unit_pkg::st_ack:
      begin
        next_state.opcode_fetch_cycle_b = 1'b0; // [RULE_05]
        next_state.io_request_strobe_b = 1'b0; // [RULE_05]
        next_state.wait_count = 2'h0;
        next_state.phase = irq_unit_pkg::st_wait;
      end
      irq_unit_pkg::st_wait:
      begin
        next_state.opcode_fetch_cycle_b = 1'b0;
        next_state.io_request_strobe_b = 1'b0;
        next_state.wait_count = 2'(state.wait_count + 2'h1);
        if (state.wait_count == `ACK_WAIT_STATES) // [RULE_06]
        begin
          next_state.opcode_fetch_cycle_b = 1'b1;
          next_state.io_request_strobe_b = 1'b1;
          next_state.ack_byte = data_in;
          if (state.response_mode_flops == `MODE_2)
          begin
            next_state.address_out = {state.interrupt_vector_base, data_in}; // [RULE_11] [RULE_12]
            next_state.memory_request_strobe_b = 1'b0;
            next_state.phase = irq_unit_pkg::st_table;
          end
          else if (data_in == `CALL_OPCODE) // [RULE_08]
          begin
            next_state.is_call = 1'b1;
            next_state.memory_request_strobe_b = 1'b0; // [RULE_09]
            next_state.phase = irq_unit_pkg::st_call_lo;
          end
          else
          begin
            next_state.injected_opcode = data_in; // [RULE_08]
            next_state.injected_valid = 1'b1;
            next_state.phase = irq_unit_pkg::st_idle;
          end
        end
      end
      irq_unit_pkg::st_call_lo, irq_unit_pkg::st_table:
      begin
        next_state.addr_lo = data_in;
        next_state.memory_request_strobe_b = 1'b0;
        next_state.address_out = 16'(state.address_out + 16'h0001);
        next_state.phase = irq_unit_pkg::st_call_hi;
      end
      irq_unit_pkg::st_call_hi:
      begin
        next_state.service_address = {data_in, state.addr_lo}; // [RULE_09] [RULE_11]
        next_state.service_valid = 1'b1;
        next_state.is_call = 1'b0;
        next_state.phase = irq_unit_pkg::st_idle;
      end
      default:
        next_state.phase = irq_unit_pkg::st_idle;
    endcase
    next_state.busy = next_state.phase != irq_unit_pkg::st_idle;
  end

  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state <= '0;
      state.phase <= irq_unit_pkg::st_idle;
      state.opcode_fetch_cycle_b <= 1'b1;
      state.io_request_strobe_b <= 1'b1;
      state.memory_request_strobe_b <= 1'b1;
      state.interrupt_vector_base <= `VECTOR_BASE_RESET;
      state.memory_refresh_counter <= `REFRESH_RESET;
      state.primary_enable_flop <= 1'b0; // [RULE_17]
      state.secondary_enable_flop <= 1'b0; // [RULE_17]
      state.response_mode_flops <= `MODE_0;
    end
    else
      state <= next_state;
  end

  assign opcode_fetch_cycle_b = state.opcode_fetch_cycle_b;
  assign io_request_strobe_b = state.io_request_strobe_b;
  assign memory_request_strobe_b = state.memory_request_strobe_b;
  assign address_out = state.address_out;
  assign refresh_phase = state.refresh_phase;
  assign interrupt_vector_base = state.interrupt_vector_base;
  assign memory_refresh_counter = state.memory_refresh_counter;
  assign primary_enable_flop = state.primary_enable_flop;
  assign secondary_enable_flop = state.secondary_enable_flop;
  assign response_mode_flops = state.response_mode_flops;
  assign parity_flag = state.parity_flag;
  assign parity_flag_valid = state.parity_flag_valid;
  assign service_address = state.service_address;
  assign service_valid = state.service_valid;
  assign injected_opcode = state.injected_opcode;
  assign injected_valid = state.injected_valid;
  assign busy = state.busy;

  a_nmi_vector: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_04]
    (state.phase == irq_unit_pkg::st_idle && instr_last_clock && bus_hold_request_b
      && !nmi_request_b) |=> (service_valid && service_address == 16'h0066))
    else $error("nmi restart address wrong");
  a_nmi_flops: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_19]
    (state.phase == irq_unit_pkg::st_idle && instr_last_clock && bus_hold_request_b
      && !nmi_request_b && !disable_instruction && !enable_instruction)
      |=> (!primary_enable_flop && secondary_enable_flop == $past(primary_enable_flop)))
    else $error("nmi enable flop copy wrong");
  a_masked_int: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_02]
    (state.phase == irq_unit_pkg::st_idle && nmi_request_b && !primary_enable_flop)
      |=> !service_valid && !busy)
    else $error("masked request was served");
  a_bus_hold_request_block: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_02]
    (state.phase == irq_unit_pkg::st_idle && !bus_hold_request_b) |=> !service_valid && !busy)
    else $error("request served during bus hold");
  a_ack_strobes: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_05]
    $rose(busy) |=> (!io_request_strobe_b && memory_request_strobe_b && !opcode_fetch_cycle_b)
      [*3] ##1 io_request_strobe_b)
    else $error("acknowledge strobes wrong");
  a_mode1_vector: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_10]
    (state.phase == irq_unit_pkg::st_idle && instr_last_clock && bus_hold_request_b
      && nmi_request_b && !int_request_b && primary_enable_flop && response_mode_flops == 2'h1)
      |=> service_valid && service_address == 16'h0038)
    else $error("mode 1 vector wrong");
  a_enable_set: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_18]
    (enable_instruction && !disable_instruction && !instr_last_clock)
      |=> primary_enable_flop && secondary_enable_flop)
    else $error("enable instruction failed");
  a_disable_clear: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_17]
    disable_instruction |=> !primary_enable_flop && !secondary_enable_flop)
    else $error("disable instruction failed");
  a_refresh_step: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_22]
    (fetch_done && !refresh_write) |=> memory_refresh_counter[6:0]
      == 7'($past(memory_refresh_counter[6:0]) + 7'h01)
      && memory_refresh_counter[7] == $past(memory_refresh_counter[7]))
    else $error("refresh step wrong");
  a_parity_copy: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_21]
    read_special |=> parity_flag_valid && parity_flag == $past(secondary_enable_flop))
    else $error("parity copy wrong");
  c_nmi: cover property (@(posedge clk) disable iff (!rst_sync_b)
    service_valid && service_address == 16'h0066);
  c_mode2: cover property (@(posedge clk) disable iff (!rst_sync_b)
    state.phase == irq_unit_pkg::st_table);
  c_call: cover property (@(posedge clk) disable iff (!rst_sync_b)
    state.phase == irq_unit_pkg::st_call_hi);
  c_inject: cover property (@(posedge clk) disable iff (!rst_sync_b) injected_valid);
  c_mode1: cover property (@(posedge clk) disable iff (!rst_sync_b)
    service_valid && service_address == `MODE1_RESTART_ADDR);
  a_return_from_nonmaskable_restore: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_20]
    (return_from_nonmaskable && !disable_instruction && !enable_instruction
      && !instr_last_clock) |=> primary_enable_flop == $past(secondary_enable_flop))
    else $error("return did not restore enable");
  a_table_addr: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_11]
    (state.phase == irq_unit_pkg::st_wait && state.wait_count == `ACK_WAIT_STATES
      && state.response_mode_flops == `MODE_2)
      |=> !memory_request_strobe_b && address_out == {interrupt_vector_base, $past(data_in)})
    else $error("vector table address wrong");
  a_call_reads: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_09]
    state.phase == irq_unit_pkg::st_call_lo |-> !memory_request_strobe_b
      ##1 !memory_request_strobe_b ##1 (memory_request_strobe_b && service_valid))
    else $error("call address reads wrong");
  a_io_only_ack: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE_05]
    !io_request_strobe_b |-> memory_request_strobe_b && !opcode_fetch_cycle_b)
    else $error("io strobe outside acknowledge");
endmodule

// file: bench/irq_chain_model.sv
/*
  Two daisy-chained peripherals sharing the maskable request line, plus a simple memory.
  Assumes the bench pulses raise/finish per device and supplies each device's ack byte.
*/
`timescale 1ns/1ps
module irq_chain_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] raise,
  input wire logic [1:0] finish,
  input wire logic [15:0] vectors,
  input wire logic opcode_fetch_cycle_b,
  input wire logic io_request_strobe_b,
  input wire logic memory_request_strobe_b,
  input wire logic [15:0] address_out,
  output logic int_request_b,
  output logic [7:0] data_in
);
  logic [1:0] pending;
  logic [1:0] serving;
  logic [1:0] acked;
  logic [1:0] grant;
  logic [2:0] enable_chain;
  logic [7:0] last_byte;
  logic acking;
  assign acking = !opcode_fetch_cycle_b && !io_request_strobe_b;
  always_comb
  begin
    enable_chain[0] = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      grant[i] = enable_chain[i] && pending[i];
      enable_chain[i + 1] = enable_chain[i] && !pending[i] && !serving[i];
    end
    int_request_b = !(|grant);
  end
  // Released bus shows the inverse of the last byte, never a stale copy
  always_comb
  begin
    data_in = ~last_byte;
    if (acking && grant[0])
      data_in = vectors[7:0];
    else if (acking && grant[1])
      data_in = vectors[15:8];
    else if (!memory_request_strobe_b)
      data_in = address_out[7:0] ^ address_out[15:8] ^ 8'h3c;
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      pending <= 2'b00;
      serving <= 2'b00;
      acked <= 2'b00;
      last_byte <= 8'h00;
    end
    else
    begin
      last_byte <= data_in;
      if (acking)
        acked <= grant;
      else
      begin
        serving <= (serving | acked) & ~finish;
        pending <= (pending | raise) & ~acked & ~finish;
        acked <= 2'b00;
      end
    end
endmodule

// file: bench/cpu_interrupt_response_unit_test.sv
/*
  Self-checking bench for the interrupt response unit with a chained peripheral model.
  Assumes the design's hand-over timing: registered outputs, one-cycle valid pulses.
*/
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
  begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", name, exp, got); end end
module cpu_interrupt_response_unit_test;
  logic clk, rst_b, nmi_request_b, bus_hold_request_b, int_request_b;
  logic [12:0] ctl;
  logic [1:0] set_mode, response_mode_flops;
  logic [7:0] write_data, data_in, interrupt_vector_base, memory_refresh_counter;
  logic [7:0] injected_opcode, rf_hi;
  logic [15:0] vectors, address_out, service_address, sv_addr;
  logic opcode_fetch_cycle_b, io_request_strobe_b, memory_request_strobe_b, refresh_phase;
  logic primary_enable_flop, secondary_enable_flop, parity_flag, parity_flag_valid;
  logic service_valid, injected_valid, busy, par_seen;
  int fail_count, n_tests, cycles, n_io, n_mem, n_fc, n_sv, n_inj, n_rf;
  cpu_interrupt_response_unit u_dut (.clk(clk), .rst_b(rst_b), .nmi_request_b(nmi_request_b),
    .int_request_b(int_request_b), .bus_hold_request_b(bus_hold_request_b),
    .instr_last_clock(ctl[0]), .fetch_done(ctl[1]), .disable_instruction(ctl[2]),
    .enable_instruction(ctl[3]), .return_from_nonmaskable(ctl[4]), .set_mode(set_mode),
    .set_mode_strobe(ctl[5]), .vector_base_write(ctl[6]), .refresh_write(ctl[7]),
    .write_data(write_data), .read_special(ctl[8]), .data_in(data_in),
    .opcode_fetch_cycle_b(opcode_fetch_cycle_b), .io_request_strobe_b(io_request_strobe_b),
    .memory_request_strobe_b(memory_request_strobe_b), .address_out(address_out),
    .refresh_phase(refresh_phase), .interrupt_vector_base(interrupt_vector_base),
    .memory_refresh_counter(memory_refresh_counter), .primary_enable_flop(primary_enable_flop),
    .secondary_enable_flop(secondary_enable_flop), .response_mode_flops(response_mode_flops),
    .parity_flag(parity_flag), .parity_flag_valid(parity_flag_valid),
    .service_address(service_address), .service_valid(service_valid),
    .injected_opcode(injected_opcode), .injected_valid(injected_valid), .busy(busy));
  irq_chain_model u_chain (.clk(clk), .rst_b(rst_b), .raise(ctl[10:9]), .finish(ctl[12:11]),
    .vectors(vectors), .opcode_fetch_cycle_b(opcode_fetch_cycle_b),
    .io_request_strobe_b(io_request_strobe_b), .memory_request_strobe_b(memory_request_strobe_b),
    .address_out(address_out), .int_request_b(int_request_b), .data_in(data_in));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tally strobes and one-cycle pulses of each operation
  always @(posedge clk)
  begin
    cycles++;
    n_io += (io_request_strobe_b === 1'b0);
    n_mem += (memory_request_strobe_b === 1'b0);
    n_fc += (opcode_fetch_cycle_b === 1'b0);
    if (service_valid === 1'b1)
    begin
      n_sv++;
      sv_addr = service_address;
    end
    n_inj += (injected_valid === 1'b1 && injected_opcode === vectors[7:0]);
    if (parity_flag_valid === 1'b1)
      par_seen = parity_flag;
    if (refresh_phase === 1'b1)
    begin
      n_rf++;
      rf_hi = address_out[15:8];
    end
    if (cycles == 5000)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task pulse(input int k);
    @(negedge clk);
    ctl[k] = 1'b1;
    @(negedge clk);
    ctl[k] = 1'b0;
  endtask
  task wr(input int k, input logic [7:0] d);
    write_data = d;
    pulse(k);
  endtask
  task take;
    n_io = 0;
    n_mem = 0;
    n_fc = 0;
    n_sv = 0;
    n_inj = 0;
    pulse(0);
    for (int i = 0; i < 12 && busy !== 1'b0; i++)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  initial
  begin
    ctl = 13'h0000;
    write_data = 8'h00;
    set_mode = 2'h0;
    vectors = 16'h20ff;
    nmi_request_b = 1'b1;
    bus_hold_request_b = 1'b1;
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    `CHECK("enables", 2'h0, {primary_enable_flop, secondary_enable_flop})
    `CHECK("base", 8'h00, interrupt_vector_base)
    wr(6, 8'h12);
    wr(7, 8'hfe);
    n_rf = 0;
    pulse(1);
    pulse(1);
    repeat (2) @(negedge clk);
    `CHECK("refresh", 8'h80, memory_refresh_counter)
    `CHECK("refresh high", 8'h12, rf_hi)
    `CHECK("refresh slots", 2, n_rf)
    for (int m = 0; m < 4; m++)
    begin
      set_mode = m[1:0];
      pulse(5);
      `CHECK("mode", (m == 3) ? 2'h2 : m[1:0], response_mode_flops)
    end
    set_mode = 2'h0;
    pulse(5);
    pulse(3);
    `CHECK("ei", 2'h3, {primary_enable_flop, secondary_enable_flop})
    pulse(8);
    repeat (2) @(negedge clk);
    `CHECK("parity", 1'b1, par_seen)
    pulse(2);
    `CHECK("di", 2'h0, {primary_enable_flop, secondary_enable_flop})
    pulse(8);
    repeat (2) @(negedge clk);
    `CHECK("parity", 1'b0, par_seen)
    pulse(9);
    take;
    `CHECK("masked", 0, n_io + n_sv + n_inj)
    pulse(3);
    bus_hold_request_b = 1'b0;
    take;
    bus_hold_request_b = 1'b1;
    `CHECK("bus hold", 0, n_io + n_sv + n_inj)
    repeat (4) @(negedge clk);
    `CHECK("no boundary", 1'b0, busy)
    nmi_request_b = 1'b0;
    take;
    nmi_request_b = 1'b1;
    `CHECK("nmi addr", 16'h0066, sv_addr)
    `CHECK("nmi order", 1, n_sv + n_io)
    `CHECK("nmi flops", 2'h1, {primary_enable_flop, secondary_enable_flop})
    pulse(4);
    `CHECK("return_from_nonmaskable", 1'b1, primary_enable_flop)
    take;
    `CHECK("ack io", 3, n_io)
    `CHECK("ack fetch", 4, n_fc + n_mem)
    `CHECK("restart", 1, n_inj)
    pulse(11);
    set_mode = 2'h1;
    pulse(5);
    pulse(3);
    pulse(9);
    take;
    `CHECK("mode1", 16'h0038, sv_addr)
    pulse(11);
    set_mode = 2'h2;
    pulse(5);
    vectors = 16'h2040;
    pulse(9);
    pulse(10);
    pulse(3);
    take;
    `CHECK("mode2", 16'h6f6e, sv_addr)
    `CHECK("mode2 reads", 2, n_mem)
    pulse(3);
    take;
    `CHECK("chain held", 0, n_sv + n_io)
    pulse(11);
    pulse(3);
    take;
    `CHECK("nested", 16'h0f0e, sv_addr)
    pulse(12);
    set_mode = 2'h0;
    pulse(5);
    vectors = 16'h20cd;
    pulse(9);
    pulse(3);
    take;
    `CHECK("call ack", 3, n_io)
    `CHECK("call reads", 2, n_mem)
    `CHECK("call done", 1, n_sv)
    report_and_stop;
  end
endmodule
